// ### rtl/bit_sync.sv
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  // Destination clock and reset.
  input  wire logic         clk,
  input  wire logic         rstn,
  // Levels from the other domain and their safe copy.
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t q, d;

  // Only the second stage reads the first; metastability settles between them.
  always_comb
  begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      q <= '0;
    else
      q <= d;
  end

  assign dout = q.s2;

endmodule // bit_sync
`default_nettype wire

// ### rtl/boundary_scan_test_port.sv
// Contract
// - Enabled test port takes its dedicated pins, except the data input line in serial-wire mode.
// - Priority oscillator, then test port, then gpio.
// - Instruction capture loads p00s or p001.
// - Instruction register shifts one bit per clock.
// - Code 0001 samples external pins into chain.
// - Code 0100 selects chain for internal test.
// - Internal test drives logic and pins from chain.
// - Internal test capture samples internal logic.
// - Data shift moves chain one cell per clock.
// - Internal test update applies chain to logic.
// - Serial-wire mode: trace out, bidirectional select.
`default_nettype none
module boundary_scan_test_port #(
  parameter int NIN  = bscan_pkg::NIN_DEF,
  parameter int NOUT = bscan_pkg::NOUT_DEF
) (
  // System clock, reset and debug mode.
  input  wire logic            mclk,
  input  wire logic            rstn,
  input  wire logic            dbg_en,
  input  wire logic            swd_mode,
  input  wire logic            prot_state,
  input  wire logic            capt_status,
  // Test link.
  input  wire logic            tck,
  input  wire logic            tms,
  input  wire logic            tdi,
  output logic                 tdo,
  output logic                 tdo_oe,
  // Line functions competing for the three claimable lines.
  input  wire logic [2:0]      gpio_out,
  input  wire logic [2:0]      gpio_oe,
  input  wire logic [2:0]      osc_claim,
  input  wire logic            swdio_out,
  input  wire logic            swdio_oe,
  input  wire logic            swdio_pad_in,
  input  wire logic            trace_out,
  output logic      [2:0]      pad_out,
  output logic      [2:0]      pad_oe,
  output logic      [5:0]      pad_owner,
  output logic                 swdio_in,
  // Core logic and functional pins.
  input  wire logic [NIN-1:0]  pin_in,
  input  wire logic [NOUT-1:0] core_out,
  output logic      [NIN-1:0]  core_in,
  output logic      [NOUT-1:0] pin_out
);

  // ****************************************
  // Types and helpers
  // ****************************************

  localparam int LEN = NIN + NOUT;
  localparam int TSW = LEN + 4;
  localparam int MSW = NIN + LEN + 2;

  typedef struct packed {
    bscan_pkg::tap_t tap;
    logic [3:0]      ir_sh;
    logic [3:0]      ir;
    logic            intest;
    logic            byp;
  } tck_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } neg_t;

  typedef struct packed {
    logic [2:0]      pad_out;
    logic [2:0]      pad_oe;
    logic [5:0]      owner;
    logic [NIN-1:0]  core_in;
    logic [NOUT-1:0] pin_out;
  } sys_t;

  // Standard controller step on the select line.
  function automatic bscan_pkg::tap_t tap_next(input bscan_pkg::tap_t s,
                                               input logic m);
    tap_next = s;
    unique case (s)
      bscan_pkg::TAP_TLR:    tap_next = m ? bscan_pkg::TAP_TLR    : bscan_pkg::TAP_IDLE;
      bscan_pkg::TAP_IDLE:   tap_next = m ? bscan_pkg::TAP_SEL_DR : bscan_pkg::TAP_IDLE;
      bscan_pkg::TAP_SEL_DR: tap_next = m ? bscan_pkg::TAP_SEL_IR : bscan_pkg::TAP_CAP_DR;
      bscan_pkg::TAP_CAP_DR: tap_next = m ? bscan_pkg::TAP_EX1_DR : bscan_pkg::TAP_SH_DR;
      bscan_pkg::TAP_SH_DR:  tap_next = m ? bscan_pkg::TAP_EX1_DR : bscan_pkg::TAP_SH_DR;
      bscan_pkg::TAP_EX1_DR: tap_next = m ? bscan_pkg::TAP_UPD_DR : bscan_pkg::TAP_PAU_DR;
      bscan_pkg::TAP_PAU_DR: tap_next = m ? bscan_pkg::TAP_EX2_DR : bscan_pkg::TAP_PAU_DR;
      bscan_pkg::TAP_EX2_DR: tap_next = m ? bscan_pkg::TAP_UPD_DR : bscan_pkg::TAP_SH_DR;
      bscan_pkg::TAP_UPD_DR: tap_next = m ? bscan_pkg::TAP_SEL_DR : bscan_pkg::TAP_IDLE;
      bscan_pkg::TAP_SEL_IR: tap_next = m ? bscan_pkg::TAP_TLR    : bscan_pkg::TAP_CAP_IR;
      bscan_pkg::TAP_CAP_IR: tap_next = m ? bscan_pkg::TAP_EX1_IR : bscan_pkg::TAP_SH_IR;
      bscan_pkg::TAP_SH_IR:  tap_next = m ? bscan_pkg::TAP_EX1_IR : bscan_pkg::TAP_SH_IR;
      bscan_pkg::TAP_EX1_IR: tap_next = m ? bscan_pkg::TAP_UPD_IR : bscan_pkg::TAP_PAU_IR;
      bscan_pkg::TAP_PAU_IR: tap_next = m ? bscan_pkg::TAP_EX2_IR : bscan_pkg::TAP_PAU_IR;
      bscan_pkg::TAP_EX2_IR: tap_next = m ? bscan_pkg::TAP_UPD_IR : bscan_pkg::TAP_SH_IR;
      bscan_pkg::TAP_UPD_IR: tap_next = m ? bscan_pkg::TAP_SEL_DR : bscan_pkg::TAP_IDLE;
    endcase
  endfunction

  // Owner of one line: the oscillator beats the test port, which beats gpio.
  function automatic bscan_pkg::owner_t line_owner(input logic osc, input logic en,
                                                   input logic swd, input logic is_tdi);
    if (osc)
      line_owner = bscan_pkg::OWN_OSC;
    else if (en && !(swd && is_tdi))
      line_owner = bscan_pkg::OWN_TEST;
    else
      line_owner = bscan_pkg::OWN_GPIO;
  endfunction

  // ****************************************
  // Test clock domain
  // ****************************************

  tck_t            t_q, t_d;
  neg_t            n_q, n_d;
  logic [TSW-1:0]  ts_out;
  logic            en_t, swd_t, prot_t, stat_t, test_on_t;
  logic [NOUT-1:0] core_out_t;
  logic [NIN-1:0]  pin_in_t;
  logic [LEN-1:0]  cap_vec, upd_vec;
  logic            chain_sel, chain_cap, chain_shift, chain_upd, chain_so;

  // System levels reach the test clock only through two stages.
  bit_sync #(.W(TSW)) u_tsync (
    .clk  (tck),
    .rstn (rstn),
    .din  ({dbg_en, swd_mode, prot_state, capt_status, core_out, pin_in}),
    .dout (ts_out)
  );

  assign {en_t, swd_t, prot_t, stat_t, core_out_t, pin_in_t} = ts_out;
  // Serial-wire mode parks the scan controller; the select line is not a scan input then.
  assign test_on_t = en_t && !swd_t;

  // Chain is the data register for both boundary instructions.
  assign chain_sel   = (t_q.ir == bscan_pkg::OP_SAMPLE) || t_q.intest;
  assign chain_cap   = chain_sel && (t_q.tap == bscan_pkg::TAP_CAP_DR);
  assign chain_shift = chain_sel && (t_q.tap == bscan_pkg::TAP_SH_DR);
  assign chain_upd   = chain_sel && (t_q.tap == bscan_pkg::TAP_UPD_DR);

  // Output cells always see the core; input cells see the pins in sampling, the applied values in internal test.
  assign cap_vec = {core_out_t, t_q.intest ? upd_vec[NIN-1:0] : pin_in_t};

  scan_chain #(.LEN(LEN)) u_chain (
    .tck     (tck),
    .rstn    (rstn),
    .cap     (chain_cap),
    .shift   (chain_shift),
    .upd     (chain_upd),
    .si      (tdi),
    .cap_vec (cap_vec),
    .so      (chain_so),
    .upd_vec (upd_vec)
  );

  // Controller and instruction path; a disabled port holds the reset state.
  always_comb
  begin
    t_d     = t_q;
    t_d.tap = test_on_t ? tap_next(t_q.tap, tms) : bscan_pkg::TAP_TLR;
    if (t_q.tap == bscan_pkg::TAP_TLR)
    begin
      t_d.ir     = bscan_pkg::OP_BYPASS;
      t_d.intest = 1'h0;
    end
    if (t_q.tap == bscan_pkg::TAP_CAP_IR)
      t_d.ir_sh = {prot_t, bscan_pkg::IR_CAP_MID,
                   (t_q.ir == bscan_pkg::OP_SAMPLE) ? stat_t : bscan_pkg::IR_CAP_LSB};
    if (t_q.tap == bscan_pkg::TAP_SH_IR)
      t_d.ir_sh = {tdi, t_q.ir_sh[3:1]};
    if (t_q.tap == bscan_pkg::TAP_UPD_IR)
    begin
      t_d.ir     = t_q.ir_sh;
      t_d.intest = (t_q.ir_sh == bscan_pkg::OP_INTEST);
    end
    if (t_q.tap == bscan_pkg::TAP_CAP_DR)
      t_d.byp = 1'h0;
    if (t_q.tap == bscan_pkg::TAP_SH_DR)
      t_d.byp = tdi;
  end

  always_ff @(posedge tck or negedge rstn)
  begin
    if (!rstn)
    begin
      t_q        <= '0;
      t_q.tap    <= bscan_pkg::TAP_TLR;
      t_q.ir     <= bscan_pkg::OP_BYPASS;
    end
    else
      t_q <= t_d;
  end

  // Serial output changes on the falling edge so the tester samples a settled bit.
  always_comb
  begin
    n_d        = n_q;
    n_d.tdo_oe = (t_q.tap == bscan_pkg::TAP_SH_IR) || (t_q.tap == bscan_pkg::TAP_SH_DR);
    if (t_q.tap == bscan_pkg::TAP_SH_IR)
      n_d.tdo = t_q.ir_sh[0];
    else if (chain_sel)
      n_d.tdo = chain_so;
    else
      n_d.tdo = t_q.byp;
  end

  always_ff @(negedge tck or negedge rstn)
  begin
    if (!rstn)
      n_q <= '0;
    else
      n_q <= n_d;
  end

  assign tdo    = n_q.tdo;
  assign tdo_oe = n_q.tdo_oe;

  // ****************************************
  // System clock domain
  // ****************************************

  sys_t            m_q, m_d;
  logic [MSW-1:0]  ms_out;
  logic            intest_m;
  logic [LEN-1:0]  upd_m;
  logic [NIN-1:0]  pin_m;
  logic [NIN-1:0]  upd_in_m;
  logic [NOUT-1:0] upd_out_m;

  // Update values are quasi-static: they change only at an update, long before the core uses them.
  bit_sync #(.W(MSW)) u_msync (
    .clk  (mclk),
    .rstn (rstn),
    .din  ({swdio_pad_in, t_q.intest, upd_vec, pin_in}),
    .dout (ms_out)
  );

  assign {swdio_in, intest_m, upd_m, pin_m} = ms_out;
  assign upd_in_m  = upd_m[NIN-1:0];
  assign upd_out_m = upd_m[LEN-1:NIN];

  // Line ownership, then what each owner drives onto its line.
  always_comb
  begin
    bscan_pkg::owner_t own;
    own = bscan_pkg::OWN_GPIO;
    m_d = m_q;
    for (int k = 0; k < bscan_pkg::LINES; k++)
    begin
      own = line_owner(osc_claim[k], dbg_en, swd_mode, k == bscan_pkg::LINE_TDI);
      m_d.owner[2*k +: 2] = own;
      m_d.pad_out[k]      = 1'h0;
      m_d.pad_oe[k]       = 1'h0;
      if (own == bscan_pkg::OWN_GPIO)
      begin
        m_d.pad_out[k] = gpio_out[k];
        m_d.pad_oe[k]  = gpio_oe[k];
      end
      else if (own == bscan_pkg::OWN_TEST && swd_mode && k == bscan_pkg::LINE_TMS)
      begin
        m_d.pad_out[k] = swdio_out;
        m_d.pad_oe[k]  = swdio_oe;
      end
      else if (own == bscan_pkg::OWN_TEST && swd_mode && k == bscan_pkg::LINE_TDO)
      begin
        m_d.pad_out[k] = trace_out;
        m_d.pad_oe[k]  = 1'h1;
      end
    end
    // Internal test swaps the core inputs and output pins over to the chain.
    m_d.core_in = intest_m ? upd_in_m : pin_m;
    m_d.pin_out = intest_m ? upd_out_m : core_out;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      m_q <= '0;
    else
      m_q <= m_d;
  end

  assign pad_out   = m_q.pad_out;
  assign pad_oe    = m_q.pad_oe;
  assign pad_owner = m_q.owner;
  assign core_in   = m_q.core_in;
  assign pin_out   = m_q.pin_out;

  // ****************************************
  // Checks
  // ****************************************

  chk_test_owns: assert property (@(posedge mclk) disable iff (!rstn)
    dbg_en && !osc_claim[0] |=> pad_owner[1:0] == bscan_pkg::OWN_TEST)
    else $error("enabled test port did not own its select line");

  chk_osc_wins: assert property (@(posedge mclk) disable iff (!rstn)
    osc_claim[1] |=> pad_owner[3:2] == bscan_pkg::OWN_OSC && !pad_oe[1])
    else $error("oscillator lost its line");

  chk_ir_capture: assert property (@(posedge tck) disable iff (!rstn)
    t_q.tap == bscan_pkg::TAP_CAP_IR && t_q.ir == bscan_pkg::OP_INTEST
    |=> t_q.ir_sh[2:0] == {bscan_pkg::IR_CAP_MID, bscan_pkg::IR_CAP_LSB} && t_q.ir_sh[3] == $past(prot_t))
    else $error("wrong instruction capture pattern");

  chk_ir_shift: assert property (@(posedge tck) disable iff (!rstn)
    t_q.tap == bscan_pkg::TAP_SH_IR |=> t_q.ir_sh == {$past(tdi), $past(t_q.ir_sh[3:1])})
    else $error("instruction register did not shift");

  chk_sample_sel: assert property (@(posedge tck) disable iff (!rstn)
    t_q.ir == bscan_pkg::OP_SAMPLE && t_q.tap == bscan_pkg::TAP_CAP_DR
    |-> chain_cap && cap_vec[NIN-1:0] == pin_in_t)
    else $error("sampling did not capture the pins");

  chk_intest_sel: assert property (@(posedge tck) disable iff (!rstn)
    t_q.tap == bscan_pkg::TAP_UPD_IR && t_q.ir_sh == bscan_pkg::OP_INTEST |=> t_q.intest && chain_sel)
    else $error("internal test did not select the chain");

  chk_intest_drive: assert property (@(posedge mclk) disable iff (!rstn)
    intest_m |=> core_in == $past(upd_in_m) && pin_out == $past(upd_out_m))
    else $error("internal test did not drive from the chain");

  chk_intest_capture: assert property (@(posedge tck) disable iff (!rstn)
    t_q.intest && t_q.tap == bscan_pkg::TAP_CAP_DR |-> chain_cap && cap_vec[LEN-1:NIN] == core_out_t)
    else $error("internal test capture missed the core");

  chk_dr_update: assert property (@(posedge tck) disable iff (!rstn)
    t_q.intest && t_q.tap == bscan_pkg::TAP_UPD_DR |=> upd_vec == $past(u_chain.q.sh))
    else $error("update did not apply the chain");

  chk_swd_trace: assert property (@(posedge mclk) disable iff (!rstn)
    dbg_en && swd_mode && !osc_claim[1] |=> pad_out[1] == $past(trace_out) && pad_oe[1])
    else $error("trace not on the data output line");

  chk_tap_reset: assert property (@(posedge tck) disable iff (!rstn)
    tms [*5] |=> t_q.tap == bscan_pkg::TAP_TLR)
    else $error("five select highs did not reset the controller");

endmodule // boundary_scan_test_port
`default_nettype wire

// ### rtl/bscan_pkg.sv
`default_nettype none
package bscan_pkg;

  // ****************************************
  // Instruction register
  // ****************************************

  // Width and codes of the instruction register.
  localparam int         IR_W       = 4;
  localparam logic [3:0] OP_SAMPLE  = 4'h1;
  localparam logic [3:0] OP_INTEST  = 4'h4;
  // Any other code selects the one-bit bypass path; reset loads this one.
  localparam logic [3:0] OP_BYPASS  = 4'hF;
  // Fixed middle bits of the capture pattern, and its low bit when sampling is not in force.
  localparam logic [1:0] IR_CAP_MID = 2'h0;
  localparam logic       IR_CAP_LSB = 1'h1;

  // ****************************************
  // Boundary chain and pins
  // ****************************************

  // Default cell counts: input cells sit at the low end of the chain.
  localparam int NIN_DEF  = 8;
  localparam int NOUT_DEF = 8;
  // Indices of the three lines that the test port can claim.
  localparam int LINE_TMS = 0;
  localparam int LINE_TDO = 1;
  localparam int LINE_TDI = 2;
  localparam int LINES    = 3;

  // Which function owns a line.
  typedef enum logic [1:0] {
    OWN_GPIO = 2'h0,
    OWN_TEST = 2'h1,
    OWN_OSC  = 2'h2
  } owner_t;

  // Controller states; codes change one bit on each step from select through pause to update.
  typedef enum logic [3:0] {
    TAP_TLR    = 4'h0,
    TAP_IDLE   = 4'h1,
    TAP_SEL_DR = 4'h3,
    TAP_CAP_DR = 4'h2,
    TAP_SH_DR  = 4'h6,
    TAP_EX1_DR = 4'h7,
    TAP_PAU_DR = 4'h5,
    TAP_EX2_DR = 4'h4,
    TAP_UPD_DR = 4'hC,
    TAP_SEL_IR = 4'hD,
    TAP_CAP_IR = 4'hF,
    TAP_SH_IR  = 4'hE,
    TAP_EX1_IR = 4'hA,
    TAP_PAU_IR = 4'hB,
    TAP_EX2_IR = 4'h9,
    TAP_UPD_IR = 4'h8
  } tap_t;

endpackage
`default_nettype wire

// ### rtl/scan_chain.sv
`default_nettype none
module scan_chain #(
  parameter int LEN = 16
) (
  // Test clock and reset.
  input  wire logic           tck,
  input  wire logic           rstn,
  // Controls from the state machine.
  input  wire logic           cap,
  input  wire logic           shift,
  input  wire logic           upd,
  // Serial path and parallel values.
  input  wire logic           si,
  input  wire logic [LEN-1:0] cap_vec,
  output logic                so,
  output logic      [LEN-1:0] upd_vec
);

  typedef struct packed {
    logic [LEN-1:0] sh;
    logic [LEN-1:0] hold;
  } chain_t;

  chain_t q, d;

  // Capture loads in parallel, shift moves one cell toward the output.
  always_comb
  begin
    d = q;
    if (cap)
      d.sh = cap_vec;
    else if (shift)
      d.sh = {si, q.sh[LEN-1:1]};
    if (upd)
      d.hold = q.sh;
  end

  always_ff @(posedge tck or negedge rstn)
  begin
    if (!rstn)
      q <= '0;
    else
      q <= d;
  end

  assign so      = q.sh[0];
  assign upd_vec = q.hold;

  // Shifting moves the chain by exactly one cell per test clock.
  chk_chain_step: assert property (@(posedge tck) disable iff (!rstn)
    shift && !cap |=> q.sh[LEN-2:0] == $past(q.sh[LEN-1:1]))
    else $error("chain did not advance by one cell");

endmodule // scan_chain
`default_nettype wire

// ### test/boundary_scan_test_port_test.sv
`default_nettype none
// ****************************************
// Self-checking bench for the scan port
// ****************************************
module boundary_scan_test_port_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk, rstn, dbg_en, swd_mode, prot_state, capt_status;
  logic       tck, tms, tdi, tdo, tdo_oe;
  logic [2:0] gpio_out, gpio_oe, osc_claim, pad_out, pad_oe;
  logic       swdio_out, swdio_oe, swdio_pad_in, trace_out, swdio_in;
  logic [5:0] pad_owner;
  logic [7:0] pin_in, core_out, core_in, pin_out;
  int         num_errors = 0;
  int         checks = 0;

  // Device and the tester that drives its test link.
  boundary_scan_test_port boundary_scan_test_port_inst (
    .mclk(mclk), .rstn(rstn), .dbg_en(dbg_en), .swd_mode(swd_mode),
    .prot_state(prot_state), .capt_status(capt_status), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .osc_claim(osc_claim), .swdio_out(swdio_out), .swdio_oe(swdio_oe),
    .swdio_pad_in(swdio_pad_in), .trace_out(trace_out), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_owner(pad_owner), .swdio_in(swdio_in), .pin_in(pin_in),
    .core_out(core_out), .core_in(core_in), .pin_out(pin_out));
  scan_prober scan_prober_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  // System clock at 100 MHz.
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************

  // Single compare for every result, widened to 16 bits.
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Levels cross two flops into the system clock domain, so let them settle first.
  task automatic settle();
    repeat (6) @(negedge mclk);
  endtask

  // Loads an instruction and judges the pattern captured before it.
  task automatic load_ir(input logic [3:0] code, input logic [3:0] exp_cap);
    logic [15:0] got;
    logic        oe;
    scan_prober_inst.scan(1'b1, 4, {12'h000, code}, got, oe);
    check_val(got, {12'h000, exp_cap});
    check_val({15'h0000, oe}, 16'h0001);
  endtask

  // One data scan of the whole chain, judged against the expected capture.
  task automatic scan_dr(input logic [15:0] din, input logic [15:0] exp);
    logic [15:0] got;
    logic        oe;
    scan_prober_inst.scan(1'b0, 16, din, got, oe);
    check_val(got, exp);
    check_val({15'h0000, oe}, 16'h0001);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************

  // Capture pattern depends on the instruction in force and on both status levels.
  task automatic t_instr();
    @(negedge mclk);
    prot_state = 1'b1;
    settle();
    load_ir(bscan_pkg::OP_SAMPLE, {1'b1, bscan_pkg::IR_CAP_MID, bscan_pkg::IR_CAP_LSB});
    load_ir(bscan_pkg::OP_INTEST, {1'b1, bscan_pkg::IR_CAP_MID, 1'b0});
    @(negedge mclk);
    prot_state = 1'b0;
    settle();
    load_ir(bscan_pkg::OP_SAMPLE, {1'b0, bscan_pkg::IR_CAP_MID, bscan_pkg::IR_CAP_LSB});
    load_ir(bscan_pkg::OP_SAMPLE, {1'b0, bscan_pkg::IR_CAP_MID, 1'b0});
    // A high status level must show in the low bit while sampling is in force.
    @(negedge mclk);
    capt_status = 1'b1;
    settle();
    load_ir(bscan_pkg::OP_SAMPLE, {1'b0, bscan_pkg::IR_CAP_MID, 1'b1});
    @(negedge mclk);
    capt_status = 1'b0;
    settle();
  endtask

  // Sampling takes the pin levels and leaves the functional paths alone.
  task automatic t_sample();
    @(negedge mclk);
    pin_in = 8'hA5;
    core_out = 8'h3C;
    settle();
    scan_dr(16'h0F0F, 16'h3CA5);
    settle();
    check_val({8'h00, core_in}, 16'h00A5);
    check_val({8'h00, pin_out}, 16'h003C);
  endtask

  // Internal test drives the core and the pins from the chain, then reads the core back.
  task automatic t_intest();
    load_ir(bscan_pkg::OP_INTEST, 4'h0);
    scan_dr(16'h965A, 16'h3C0F);
    @(negedge mclk);
    pin_in = 8'hFF;
    core_out = 8'hC3;
    settle();
    check_val({8'h00, core_in}, 16'h005A);
    check_val({8'h00, pin_out}, 16'h0096);
    scan_dr(16'h0000, 16'hC35A);
  endtask

  // Line ownership under each enable, and the serial-wire reuse of the lines.
  task automatic t_pins();
    @(negedge mclk);
    dbg_en = 1'b0;
    gpio_out = 3'b101;
    gpio_oe = 3'b111;
    settle();
    check_val({4'h0, pad_owner, pad_out, pad_oe}, {4'h0, 6'h00, 3'b101, 3'b111});
    dbg_en = 1'b1;
    settle();
    check_val({10'h000, pad_owner}, 16'h0015);
    osc_claim = 3'b010;
    settle();
    check_val({9'h000, pad_owner, pad_oe[1]}, {9'h000, 6'h19, 1'b0});
    osc_claim = 3'b000;
    swd_mode = 1'b1;
    // Serial-wire and trace levels differ from the gpio levels, so a wrong owner shows.
    swdio_out = 1'b0;
    swdio_oe = 1'b1;
    trace_out = 1'b1;
    swdio_pad_in = 1'b1;
    settle();
    check_val({6'h00, pad_owner[5:4], pad_out, pad_oe, swdio_in, tdo_oe},
              {6'h00, 2'b00, 3'b110, 3'b111, 1'b1, 1'b0});
  endtask

  // Main sequence: reset for 12 cycles, park the controller, then the scenarios.
  initial
  begin
    rstn = 1'b0;
    dbg_en = 1'b1;
    swd_mode = 1'b0;
    prot_state = 1'b0;
    capt_status = 1'b0;
    gpio_out = 3'b000;
    gpio_oe = 3'b000;
    osc_claim = 3'b000;
    swdio_out = 1'b0;
    swdio_oe = 1'b0;
    swdio_pad_in = 1'b0;
    trace_out = 1'b0;
    pin_in = 8'h00;
    core_out = 8'h00;
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    settle();
    check_val({15'h0000, tdo_oe}, 16'h0000);
    scan_prober_inst.go_idle();
    t_instr();
    t_sample();
    t_intest();
    t_pins();
    wrap_up();
  end

  // The whole run needs under two microseconds; a hang is cut off far beyond that.
  initial
  begin
    #100us;
    num_errors++;
    wrap_up();
  end
endmodule // boundary_scan_test_port_test
`default_nettype wire

// ### test/scan_prober.sv
`default_nettype none
// ****************************************
// Tester model on the test link
// ****************************************
module scan_prober (
  // Test link toward the device.
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // The clock stands still low between frames, as a real probe leaves it.
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One test clock of 6 ns: drive after the fall, sample the output just before the rise.
  task automatic step(input logic t, input logic d, output logic o, output logic e);
    tms = t;
    tdi = d;
    #3;
    o = tdo;
    e = tdo_oe;
    tck = 1'b1;
    #3;
    tck = 1'b0;
  endtask

  // Five high mode bits reach reset from any state, then one low bit parks in idle.
  // Outside shifting the data line toggles, so no stale level looks like valid data.
  task automatic go_idle();
    logic o;
    logic e;
    repeat (5) step(1'b1, ~tdi, o, e);
    step(1'b0, ~tdi, o, e);
  endtask

  // One scan of n bits, low bit first, from idle back to idle.
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout, output logic oe_all);
    logic o;
    logic e;
    dout = '0;
    oe_all = 1'b1;
    step(1'b1, ~tdi, o, e);
    if (ir)
      step(1'b1, ~tdi, o, e);
    step(1'b0, ~tdi, o, e);
    step(1'b0, ~tdi, o, e);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o, e);
      dout[i] = o;
      oe_all &= e;
    end
    step(1'b1, ~tdi, o, e);
    step(1'b0, ~tdi, o, e);
  endtask
endmodule // scan_prober
`default_nettype wire
